//--- core/sbcff_pkg.sv
// Constants and carrier types of the fault flag bank
package sbcff_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_FREQ_MHZ = 40;
    localparam int T_QUAL_US = 100;
    localparam int QUAL_CYC = T_QUAL_US * CLK_FREQ_MHZ;
    localparam int T_RST_SHORT_MS = 100;
    localparam int RST_SHORT_CYC = T_RST_SHORT_MS * 1000 * CLK_FREQ_MHZ;

    // ==========================================================
    // Latched flag positions
    localparam int NUM_FLAGS = 12;
    localparam int FLG_AUX_LOW = 0;
    localparam int FLG_AUX_OC = 1;
    localparam int FLG_XCVR_THERMAL = 2;
    localparam int FLG_XCVR_UV = 3;
    localparam int FLG_XCVR_OC = 4;
    localparam int FLG_SENSE_LOW = 5;
    localparam int FLG_SUPPLY_UV = 6;
    localparam int FLG_CORE_OC_RUN = 7;
    localparam int FLG_CORE_THERMAL = 8;
    localparam int FLG_SHORT_RST = 9;
    localparam int FLG_SUPPLY_LOSS = 10;
    localparam int FLG_CORE_OC_LP = 11;
    // Flags that need the qualification delay before setting
    localparam logic [11:0] FILTER_MASK = 12'h8FB;

    // ==========================================================
    // Read commands and read data layout
    localparam logic [15:0] CMD_READ_REG_FLAGS = 16'hE100;
    localparam logic [15:0] CMD_READ_CAN_FLAGS = 16'hE180;
    localparam logic [15:0] CMD_READ_CAN_STATUS = 16'h2180;
    localparam int CAN_FLAGS_WAKE_BIT = 0;

    // ==========================================================
    // Reset values
    localparam logic WAKE_RX_RST = 1'b1;
    localparam logic [15:0] RD_DATA_RST = 16'h0000;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic core_rail_overcurrent_lp_flag;
        logic supply_loss_flag;
        logic short_reset_pulse_flag;
        logic core_rail_thermal_flag;
        logic core_rail_overcurrent_run_flag;
        logic supply_undervolt_flag;
        logic sense_input_low_flag;
        logic xcvr_supply_overcurrent_flag;
        logic xcvr_supply_undervolt_flag;
        logic xcvr_supply_thermal_flag;
        logic aux_rail_overcurrent_flag;
        logic aux_rail_low_flag;
    } sbcff_reg_flags_t;

    typedef struct packed {
        logic bus_wake_receiver_live_state;
        logic receiver_live_state;
        logic driver_live_state;
    } sbcff_can_live_t;

endpackage : sbcff_pkg

//--- core/sbcff_sync.sv
// Two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
module sbcff_sync
    import sbcff_pkg::*;
#(
    parameter int WIDTH = 1,
    // Idle level of each input, so that no false edge follows reset
    parameter logic [WIDTH-1:0] RST_VAL = '0
)(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] stage_reg;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            meta_reg <= RST_VAL;
            stage_reg <= RST_VAL;
        end
        else
        begin
            meta_reg <= async_in;
            stage_reg <= meta_reg;
        end
    end

    assign sync_out = stage_reg;
endmodule : sbcff_sync

//--- core/sbcff_flag_cell.sv
// One latched fault flag with optional qualification timer
`timescale 1ns/1ps
module sbcff_flag_cell
    import sbcff_pkg::*;
#(
    parameter bit FILTERED = 1'b1,
    parameter int QUAL = QUAL_CYC
)(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Condition and read
    input wire logic cond,
    input wire logic read_clr,
    // Flag
    output logic flag
);
    localparam int CW = $clog2(QUAL + 1);
    localparam logic [CW-1:0] QUAL_W = CW'(QUAL);

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic flag_reg;
    logic flag_next;
    logic set_now;

    // ==========================================================
    // Qualification and latch
    always_comb
    begin
        cnt_next = cnt_reg;
        if (!cond)
            cnt_next = '0;
        else if (cnt_reg != QUAL_W)
            cnt_next = cnt_reg + 1'b1;
        // Count equals QUAL only after QUAL cycles, so the set lands strictly past the time
        set_now = FILTERED ? (cond && cnt_reg == QUAL_W) : cond;
        // Set wins; a read only clears once the condition is gone
        flag_next = set_now | (flag_reg & ~(read_clr & ~cond));
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cnt_reg <= '0;
            flag_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            flag_reg <= flag_next;
        end
    end

    assign flag = flag_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_qual_sets_flag: assert property ((cond && cnt_reg == QUAL_W) |=> flag_reg)
        else $error("qualified condition did not set flag");
    a_short_cond_no: assert property ((FILTERED && !flag_reg && (!cond || cnt_reg != QUAL_W)) |=> !flag_reg)
        else $error("flag set before qualification time");
    a_restart_timer: assert property ((!cond) |=> (cnt_reg == '0))
        else $error("qualification timer not restarted");
endmodule : sbcff_flag_cell

//--- core/sbcff_fault_flag_bank.sv
// Fault flag bank: latched supply and thermal flags, CAN live state and wake flag
// Notes on behaviour
// - Aux rail low flag sets after more than 100 us undervoltage; read-clears once recovered.
// - Aux rail overcurrent flag sets after more than 100 us; read-clears after current drops.
// - Transceiver supply thermal flag sets while hot; read-clears once cooled.
// - Transceiver supply undervoltage flag sets after more than 100 us; read-clears after recovery.
// - Transceiver supply overcurrent flag sets after more than 100 us; read-clears after recovery.
// - Sense input low flag sets after more than 100 us low; read-clears once above.
// - Supply undervoltage flag sets after more than 100 us; read-clears once above threshold.
// - In run mode, core rail overcurrent over 100 us sets flag; read-clears after.
// - Core rail thermal flag sets on thermal switch-off; read-clears once recovered.
// - Reset-pin low pulse shorter than 100 ms sets flag; read-clears after pulse ends.
// - Supply loss flag sets below battery-fail level; read-clears once above.
// - In low-power core-on mode, overcurrent over 100 us sets separate flag.
// - Driver live state is 1 when enabled, 0 when configured off or faulted.
// - CAN status read leaves driver, receiver and wake-receiver live bits unchanged.
// - Receiver live state is 1 when enabled, 0 when disabled by configuration.
// - Wake receiver live state follows host control and is enabled after reset.
// - CAN wake flag sets on detected bus wake; cleared when host reads it.
`timescale 1ns/1ps
module sbcff_fault_flag_bank
    import sbcff_pkg::*;
#(
    parameter int QUAL = QUAL_CYC,
    parameter int RST_SHORT = RST_SHORT_CYC
)(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Analog comparator levels, asynchronous
    input wire logic aux_rail_uv,
    input wire logic aux_rail_oc,
    input wire logic xcvr_supply_hot,
    input wire logic xcvr_supply_uv,
    input wire logic xcvr_supply_oc,
    input wire logic sense_input_below,
    input wire logic supply_below_low,
    input wire logic core_rail_oc,
    input wire logic core_rail_oc_lp,
    input wire logic core_rail_hot_off,
    input wire logic supply_below_batfail,
    // Pins, asynchronous
    input wire logic reset_pin_n,
    input wire logic can_wake_detect,
    // Operating mode, same clock
    input wire logic mode_run,
    input wire logic mode_low_power_core_on,
    // CAN configuration, same clock
    input wire logic can_driver_cfg_en,
    input wire logic can_txd_dom_fault,
    input wire logic can_receiver_cfg_en,
    input wire logic wake_rx_enable_set,
    input wire logic wake_rx_enable_clr,
    // Host read port, same clock
    input wire logic rd_strobe,
    input wire logic [15:0] rd_cmd,
    output logic rd_valid,
    output logic [15:0] rd_data,
    // Flag and state view
    output sbcff_reg_flags_t reg_flags,
    output logic can_wake_flag,
    output sbcff_can_live_t can_live
);
    localparam int RW = $clog2(RST_SHORT + 1);
    localparam logic [RW-1:0] RST_SHORT_W = RW'(RST_SHORT);

    // ==========================================================
    // Synchronisers
    logic [10:0] cond_async;
    logic [10:0] cond_sync;
    logic [1:0] pin_sync;
    logic reset_pin_s;
    logic wake_det_s;

    assign cond_async = {core_rail_oc_lp, supply_below_batfail, core_rail_hot_off, core_rail_oc,
                         supply_below_low, sense_input_below, xcvr_supply_oc, xcvr_supply_uv,
                         xcvr_supply_hot, aux_rail_oc, aux_rail_uv};

    sbcff_sync #(.WIDTH(11)) u_cond_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in(cond_async),
        .sync_out(cond_sync)
    );

    // Reset pin flops start high, its idle level; a low start would fake a short pulse
    sbcff_sync #(.WIDTH(2), .RST_VAL(2'h1)) u_pin_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async_in({can_wake_detect, reset_pin_n}),
        .sync_out(pin_sync)
    );
    assign reset_pin_s = pin_sync[0];
    assign wake_det_s = pin_sync[1];

    // ==========================================================
    // Read decode
    function automatic logic cmd_is(input logic [15:0] cmd, input logic [15:0] code);
        cmd_is = (cmd == code);
    endfunction : cmd_is

    logic rd_reg_flags;
    logic rd_can_flags;
    logic rd_can_status;

    assign rd_reg_flags = rd_strobe && cmd_is(rd_cmd, CMD_READ_REG_FLAGS);
    assign rd_can_flags = rd_strobe && cmd_is(rd_cmd, CMD_READ_CAN_FLAGS);
    // Status read has no side effect on any bit
    assign rd_can_status = rd_strobe && cmd_is(rd_cmd, CMD_READ_CAN_STATUS);

    // ==========================================================
    // Flag conditions
    logic [NUM_FLAGS-1:0] cond_vec;
    logic [NUM_FLAGS-1:0] flag_vec;

    always_comb
    begin
        cond_vec = '0;
        cond_vec[FLG_AUX_LOW] = cond_sync[0];
        cond_vec[FLG_AUX_OC] = cond_sync[1];
        cond_vec[FLG_XCVR_THERMAL] = cond_sync[2];
        cond_vec[FLG_XCVR_UV] = cond_sync[3];
        cond_vec[FLG_XCVR_OC] = cond_sync[4];
        cond_vec[FLG_SENSE_LOW] = cond_sync[5];
        cond_vec[FLG_SUPPLY_UV] = cond_sync[6];
        cond_vec[FLG_CORE_OC_RUN] = cond_sync[7] && mode_run;
        cond_vec[FLG_CORE_THERMAL] = cond_sync[8];
        cond_vec[FLG_SUPPLY_LOSS] = cond_sync[9];
        cond_vec[FLG_CORE_OC_LP] = cond_sync[10] && mode_low_power_core_on;
        // Short reset pulse is handled by its own detector below
        cond_vec[FLG_SHORT_RST] = 1'b0;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FLAGS; gi++)
        begin : g_flag
            if (gi != FLG_SHORT_RST)
            begin : g_cell
                sbcff_flag_cell #(
                    .FILTERED(FILTER_MASK[gi]),
                    .QUAL(QUAL)
                ) u_cell (
                    .ref_clk(ref_clk),
                    .reset(reset),
                    .cond(cond_vec[gi]),
                    .read_clr(rd_reg_flags),
                    .flag(flag_vec[gi])
                );
            end
        end
    endgenerate

    // ==========================================================
    // Reset pin short pulse detector
    logic [RW-1:0] low_cnt_reg;
    logic [RW-1:0] low_cnt_next;
    logic pin_prev_reg;
    logic pin_prev_next;
    logic short_flag_reg;
    logic short_flag_next;
    logic pulse_end;

    always_comb
    begin
        pin_prev_next = reset_pin_s;
        low_cnt_next = low_cnt_reg;
        if (reset_pin_s)
            low_cnt_next = '0;
        else if (low_cnt_reg != RST_SHORT_W)
            low_cnt_next = low_cnt_reg + 1'b1;
        // Low phase counted from the synchronised pin; a pin held low through reset still counts
        pulse_end = reset_pin_s && !pin_prev_reg && low_cnt_reg != '0;
        short_flag_next = (pulse_end && low_cnt_reg < RST_SHORT_W)
                        | (short_flag_reg & ~(rd_reg_flags & reset_pin_s));
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            low_cnt_reg <= '0;
            pin_prev_reg <= 1'b1;
            short_flag_reg <= 1'b0;
        end
        else
        begin
            low_cnt_reg <= low_cnt_next;
            pin_prev_reg <= pin_prev_next;
            short_flag_reg <= short_flag_next;
        end
    end

    assign flag_vec[FLG_SHORT_RST] = short_flag_reg;

    // ==========================================================
    // CAN live state and wake flag
    sbcff_can_live_t live_reg;
    sbcff_can_live_t live_next;
    logic wake_rx_reg;
    logic wake_rx_next;
    logic wake_prev_reg;
    logic wake_flag_reg;
    logic wake_flag_next;
    logic wake_event;

    always_comb
    begin
        wake_rx_next = wake_rx_reg;
        if (wake_rx_enable_clr)
            wake_rx_next = 1'b0;
        else if (wake_rx_enable_set)
            wake_rx_next = 1'b1;
        live_next.driver_live_state = can_driver_cfg_en && !can_txd_dom_fault;
        live_next.receiver_live_state = can_receiver_cfg_en;
        live_next.bus_wake_receiver_live_state = wake_rx_reg;
        wake_event = wake_det_s && !wake_prev_reg;
        // A wake in the same cycle as the read is kept
        wake_flag_next = wake_event | (wake_flag_reg & ~rd_can_flags);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            live_reg <= '0;
            wake_rx_reg <= WAKE_RX_RST;
            wake_prev_reg <= 1'b0;
            wake_flag_reg <= 1'b0;
        end
        else
        begin
            live_reg <= live_next;
            wake_rx_reg <= wake_rx_next;
            wake_prev_reg <= wake_det_s;
            wake_flag_reg <= wake_flag_next;
        end
    end

    // ==========================================================
    // Read data
    logic [15:0] rd_data_reg;
    logic [15:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;

    always_comb
    begin
        rd_data_next = rd_data_reg;
        rd_valid_next = rd_strobe;
        if (rd_reg_flags)
            rd_data_next = {4'h0, flag_vec};
        else if (rd_can_flags)
            rd_data_next = 16'(wake_flag_reg) << CAN_FLAGS_WAKE_BIT;
        else if (rd_can_status)
            rd_data_next = {13'h0000, live_reg};
        else if (rd_strobe)
            rd_data_next = RD_DATA_RST;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            rd_data_reg <= RD_DATA_RST;
            rd_valid_reg <= 1'b0;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign reg_flags = sbcff_reg_flags_t'(flag_vec);
    assign can_wake_flag = wake_flag_reg;
    assign can_live = live_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_read_reg;
        rd_reg_flags;
    endsequence

    sequence s_short_pulse_end;
        pulse_end && low_cnt_reg < RST_SHORT_W;
    endsequence

    a_active_survives_read: assert property ((s_read_reg) |=>
        ((flag_vec & $past(flag_vec & cond_vec)) == $past(flag_vec & cond_vec)))
        else $error("active flag lost on read");
    a_batfail_sets: assert property (cond_sync[9] |=> flag_vec[FLG_SUPPLY_LOSS])
        else $error("supply loss flag not set");
    a_thermal_core_set: assert property (cond_sync[8] |=> flag_vec[FLG_CORE_THERMAL])
        else $error("core thermal flag not set");
    a_core_oc_lp_gated: assert property ((!mode_low_power_core_on && !flag_vec[FLG_CORE_OC_LP]) |=>
        !flag_vec[FLG_CORE_OC_LP])
        else $error("low power overcurrent flag set outside mode");
    a_short_pulse_flag: assert property (s_short_pulse_end |=> short_flag_reg)
        else $error("short reset pulse not flagged");
    a_drv_live_state: assert property (1'b1 |=>
        (live_reg.driver_live_state == $past(can_driver_cfg_en && !can_txd_dom_fault)))
        else $error("driver live state wrong");
    a_rx_live_state: assert property (1'b1 |=> (live_reg.receiver_live_state == $past(can_receiver_cfg_en)))
        else $error("receiver live state wrong");
    a_wake_rx_default: assert property ($fell(reset) |-> live_next.bus_wake_receiver_live_state)
        else $error("wake receiver not enabled after reset");
    a_status_read_pure: assert property ((rd_can_status && !wake_event) |=>
        ($stable(wake_flag_reg) && rd_data_reg[2:0] == $past(live_reg)))
        else $error("status read disturbed state");
    a_wake_flag_set: assert property (wake_event |=> wake_flag_reg ##1 (wake_flag_reg || $past(rd_can_flags)))
        else $error("wake flag not set");
    a_wake_flag_read: assert property ((rd_can_flags && !wake_event) |=> !wake_flag_reg)
        else $error("wake flag not cleared by read");
endmodule : sbcff_fault_flag_bank

//--- verification/sbcff_host_model.sv
// Host model that reads the flag bank over its read port
`timescale 1ns/1ps
module sbcff_host_model
    import sbcff_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Read request
    output logic rd_strobe,
    output logic [15:0] rd_cmd,
    // Read answer
    input wire logic rd_valid,
    input wire logic [15:0] rd_data
);
    initial
    begin
        rd_strobe = 1'b0;
        rd_cmd = 16'h0000;
    end

    // One-cycle strobe; the answer is taken at the next falling edge,
    // while the one-cycle valid pulse still stands
    task automatic read(input logic [15:0] cmd, output logic [15:0] data, output logic vld);
        @(negedge ref_clk);
        rd_strobe = 1'b1;
        rd_cmd = cmd;
        @(negedge ref_clk);
        rd_strobe = 1'b0;
        // Released command lines show no stale value
        rd_cmd = ~cmd;
        vld = rd_valid;
        data = rd_data;
    endtask : read
endmodule : sbcff_host_model

//--- verification/testbench.sv
// Self-checking bench of the fault flag bank
`timescale 1ns/1ps
module testbench
    import sbcff_pkg::*;
;
    localparam int QUAL_T = 20;
    localparam int RST_T = 50;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [11:0] cond_v = 12'h000;
    logic reset_pin_n = 1'b1;
    logic can_wake_detect = 1'b0;
    logic mode_run = 1'b0;
    logic mode_lp = 1'b0;
    logic drv_en = 1'b1;
    logic txd_fault = 1'b0;
    logic rx_en = 1'b1;
    logic wk_set = 1'b0;
    logic wk_clr = 1'b0;
    logic rd_strobe;
    logic [15:0] rd_cmd;
    logic rd_valid;
    logic [15:0] rd_data;
    sbcff_reg_flags_t reg_flags;
    logic can_wake_flag;
    sbcff_can_live_t can_live;
    int mismatches = 0;
    int tests_run = 0;

    always #12.5 ref_clk = ~ref_clk;

    sbcff_fault_flag_bank #(.QUAL(QUAL_T), .RST_SHORT(RST_T)) sbcff_fault_flag_bank_i (
        .ref_clk(ref_clk), .reset(reset),
        .aux_rail_uv(cond_v[0]), .aux_rail_oc(cond_v[1]), .xcvr_supply_hot(cond_v[2]),
        .xcvr_supply_uv(cond_v[3]), .xcvr_supply_oc(cond_v[4]), .sense_input_below(cond_v[5]),
        .supply_below_low(cond_v[6]), .core_rail_oc(cond_v[7]), .core_rail_oc_lp(cond_v[11]),
        .core_rail_hot_off(cond_v[8]), .supply_below_batfail(cond_v[10]),
        .reset_pin_n(reset_pin_n), .can_wake_detect(can_wake_detect),
        .mode_run(mode_run), .mode_low_power_core_on(mode_lp),
        .can_driver_cfg_en(drv_en), .can_txd_dom_fault(txd_fault), .can_receiver_cfg_en(rx_en),
        .wake_rx_enable_set(wk_set), .wake_rx_enable_clr(wk_clr),
        .rd_strobe(rd_strobe), .rd_cmd(rd_cmd), .rd_valid(rd_valid), .rd_data(rd_data),
        .reg_flags(reg_flags), .can_wake_flag(can_wake_flag), .can_live(can_live));

    sbcff_host_model sbcff_host_model_i (
        .ref_clk(ref_clk), .rd_strobe(rd_strobe), .rd_cmd(rd_cmd),
        .rd_valid(rd_valid), .rd_data(rd_data));

    // ==========================================================
    // Helpers
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    task automatic rd(input logic [15:0] cmd, output logic [15:0] d);
        logic v;
        sbcff_host_model_i.read(cmd, d, v);
        chk({15'h0000, v}, 16'h0001);
    endtask : rd

    function automatic logic [15:0] flags16();
        return {4'h0, reg_flags};
    endfunction : flags16

    // Filtered flags first see a short burst that must not latch
    task automatic flag_case(input int i);
        logic [15:0] d;
        logic [15:0] m;
        int h;
        m = 16'h0001 << i;
        h = 2 + int'($urandom % (QUAL_T - 4));
        cond_v[i] = 1'b1;
        if (FILTER_MASK[i])
        begin
            cyc(h);
            cond_v[i] = 1'b0;
            cyc(3);
            cond_v[i] = 1'b1;
            cyc(QUAL_T - 1);
            chk(flags16(), 16'h0000);
        end
        cyc(8);
        chk(flags16(), m);
        rd(CMD_READ_REG_FLAGS, d);
        chk(d, m);
        chk(flags16(), m);
        cond_v[i] = 1'b0;
        cyc(4);
        rd(CMD_READ_REG_FLAGS, d);
        chk(d, m);
        chk(flags16(), 16'h0000);
    endtask : flag_case

    // ==========================================================
    // Main sequence
    initial
    begin
        logic [15:0] d;
        logic [2:0] r;
        logic wk;
        void'($urandom(52));
        cyc(20);
        reset = 1'b0;
        cyc(3);
        wk = 1'b1;
        chk({13'h0000, can_live}, 16'h0007);
        chk(flags16(), 16'h0000);
        mode_run = 1'b1;
        mode_lp = 1'b1;
        for (int i = 0; i < NUM_FLAGS; i++)
            if (i != FLG_SHORT_RST)
                flag_case(i);
        // Overcurrent outside its mode must not latch
        mode_run = 1'b0;
        mode_lp = 1'b0;
        cond_v = 12'h880;
        cyc(QUAL_T + 8);
        chk(flags16(), 16'h0000);
        cond_v = 12'h000;
        // Reset pin pulses, short then long
        reset_pin_n = 1'b0;
        cyc(1 + int'($urandom % (RST_T - 10)));
        reset_pin_n = 1'b1;
        cyc(5);
        chk(flags16(), 16'h0200);
        rd(CMD_READ_REG_FLAGS, d);
        chk(d, 16'h0200);
        chk(flags16(), 16'h0000);
        // A low phase of exactly the limit is not short
        reset_pin_n = 1'b0;
        cyc(RST_T);
        reset_pin_n = 1'b1;
        cyc(5);
        chk(flags16(), 16'h0000);
        // Live CAN state under random configuration
        for (int k = 0; k < 8; k++)
        begin
            r = (k == 0) ? 3'b011 : 3'($urandom);
            drv_en = r[0];
            txd_fault = r[1];
            rx_en = r[2];
            cyc(3);
            chk({13'h0000, can_live}, {13'h0000, wk, r[2], r[0] & ~r[1]});
            rd(CMD_READ_CAN_STATUS, d);
            chk(d, {13'h0000, wk, r[2], r[0] & ~r[1]});
            cyc(2);
            chk({13'h0000, can_live}, {13'h0000, wk, r[2], r[0] & ~r[1]});
            // Walk the wake receiver through clear, set and both
            wk_clr = (k % 3) != 1;
            wk_set = (k % 3) != 0;
            cyc(1);
            wk_clr = 1'b0;
            wk_set = 1'b0;
            wk = (k % 3) == 1;
            cyc(3);
            chk({15'h0000, can_live[2]}, {15'h0000, wk});
        end
        // Bus wake flag clears on its own read only
        can_wake_detect = 1'b1;
        cyc(5);
        chk({15'h0000, can_wake_flag}, 16'h0001);
        rd(CMD_READ_REG_FLAGS, d);
        chk({15'h0000, can_wake_flag}, 16'h0001);
        rd(CMD_READ_CAN_FLAGS, d);
        chk(d, 16'h0001);
        chk({15'h0000, can_wake_flag}, 16'h0000);
        rd(CMD_READ_CAN_FLAGS, d);
        chk(d, 16'h0000);
        can_wake_detect = 1'b0;
        rd(16'h1234, d);
        chk(d, 16'h0000);
        print_verdict();
    end

    initial
    begin
        #1ms;
        mismatches++;
        print_verdict();
    end
endmodule : testbench
